// ==== hw/hbic_device.sv ====
// Device end: host port, channel FIFOs, DMA requests, interrupt cascade.
// Operation
// R1: Straps pick bus width and bus style.
// R2: Nine address bits, chip select, strobes decode.
// R3: Low address bit and lane enable pick size.
// R4: Each channel has 64-byte transmit, receive FIFOs.
// R5: Sixteen DMA requests, one per direction per channel.
// R6: DMA works without acknowledge inputs.
// R7: Config register picks slave or daisy cascading.
// R8: Slave selected when select inputs match identity.
// R9: Two-pulse acknowledge on the strobe-pair style bus.
// R10: Chain output feeds next device; top input high.
// R11: Third select input held fixed in daisy mode.
// R12: Chain settles between the two acknowledge pulses.
// R13: Chain settles before data strobe falls, other style.
// R14: Glue derives lane enable from size, address.
// R15: Glue answers sixteen-bit port size on accesses.
// R16: Byte uses one lane; both high means nothing.
// R17: Unselected device leaves data bus released.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module hbic_device
	import hbic_pkg::*;
(
	input  logic       clk,
	input  logic       rst_n,
	hbic_if.dev        bus,
	input  logic       rx_push,
	input  logic [2:0] rx_push_ch,
	input  logic [7:0] rx_push_data,
	output logic [7:0] rx_full,
	input  logic       tx_pop,
	input  logic [2:0] tx_pop_ch,
	output logic [7:0] tx_pop_data,
	output logic [7:0] tx_empty
);
	// ==========================================================
	// Straps
	logic bus16_reg;
	logic moto_reg;
	logic strap_done_reg;

	// Straps are static, so one capture after reset release suffices.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bus16_reg      <= 1'b0;
			moto_reg       <= 1'b0;
			strap_done_reg <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			bus16_reg      <= bus.strap_bus16; // R1
			moto_reg       <= bus.strap_moto; // R1
			strap_done_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Access decode
	logic        acc_prev_reg;
	wire  [2:0]  ch       = bus.addr[8:6];
	wire  [5:0]  off      = {bus.addr[5:1], 1'b0};
	wire         lane_n   = moto_reg ? bus.lower_lane_enable_n : bus.upper_lane_enable_n;
	wire         even_en  = ~bus.addr[0]; // R3
	wire         odd_en   = bus16_reg ? ~lane_n : bus.addr[0]; // R16
	wire  [1:0]  nbytes   = {1'b0, even_en} + {1'b0, odd_en};
	wire         strobe   = moto_reg ? ~bus.host_data_strobe_n :
		(~bus.host_data_strobe_n | ~bus.wr_rw); // R2
	wire         is_rd    = moto_reg ? bus.wr_rw : ~bus.host_data_strobe_n; // R2
	// DMA acknowledge inputs play no part, so plain select/strobe DMA works.
	wire         acc_on   = ~bus.cs_n & bus.interrupt_acknowledge_strobe_n & strobe; // R2 R6
	wire         acc_go   = acc_on & ~acc_prev_reg;
	wire         fifo_sel = off == HBIC_OFF_FIFO;
	wire         do_wr    = acc_go & ~is_rd & (nbytes != 2'h0); // R16
	wire         do_rd    = acc_go & is_rd;
	wire  [7:0]  w_even   = (bus16_reg & moto_reg) ? bus.data[15:8] : bus.data[7:0];
	wire  [7:0]  w_odd    = (bus16_reg & ~moto_reg) ? bus.data[15:8] : bus.data[7:0];
	wire  [15:0] wword    = {w_odd, w_even};
	wire  [15:0] be       = {{8{odd_en}}, {8{even_en}}};

	// ==========================================================
	// FIFO storage, one 64-byte pool per channel and direction
	logic [7:0]       tx_mem [512];
	logic [7:0]       rx_mem [512];
	wire  [7:0][6:0]  tx_cnt;
	wire  [7:0][6:0]  rx_cnt;
	wire  [7:0][5:0]  tx_wp;
	wire  [7:0][5:0]  tx_rp;
	wire  [7:0][5:0]  rx_wp;
	wire  [7:0][5:0]  rx_rp;
	wire  [15:0]      ev;
	logic [7:0]       dmaen_reg;

	wire [6:0] h_tx_cnt  = tx_cnt[ch];
	wire [6:0] h_rx_cnt  = rx_cnt[ch];
	// A host access that does not fit entirely is dropped whole.
	wire       tx_push_ok = do_wr & fifo_sel & (h_tx_cnt + {5'h0, nbytes} <= HBIC_DEPTH);
	wire       rx_pop_ok  = do_rd & fifo_sel & (nbytes != 2'h0) &
		(h_rx_cnt >= {5'h0, nbytes});
	wire [1:0] tx_push_k  = tx_push_ok ? nbytes : 2'h0;
	wire [1:0] rx_pop_k   = rx_pop_ok ? nbytes : 2'h0;
	wire [5:0] tw0        = tx_wp[ch];
	wire [5:0] tw1        = tw0 + {5'h0, even_en};
	wire [5:0] rr0        = rx_rp[ch];
	wire [5:0] rr1        = rr0 + {5'h0, even_en};
	wire [7:0] r_even     = rx_mem[{ch, rr0}];
	wire [7:0] r_odd      = rx_mem[{ch, rr1}];
	wire       rx_push_ok = rx_push & (rx_cnt[rx_push_ch] != HBIC_DEPTH);
	wire       tx_pop_ok  = tx_pop & (tx_cnt[tx_pop_ch] != 7'h00);

	// The even byte goes first into the pool, so word order is fixed.
	always_ff @(posedge clk)
	begin
		if (tx_push_ok & even_en)
			tx_mem[{ch, tw0}] <= w_even; // R4
		if (tx_push_ok & odd_en)
			tx_mem[{ch, tw1}] <= w_odd; // R4
		if (rx_push_ok)
			rx_mem[{rx_push_ch, rx_wp[rx_push_ch]}] <= rx_push_data; // R4
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tx_pop_data <= 8'h00;
		else if (tx_pop_ok)
			tx_pop_data <= tx_mem[{tx_pop_ch, tx_rp[tx_pop_ch]}];
	end

	for (genvar i = 0; i < HBIC_NCH; i++)
	begin : g_ch
		logic [6:0] txc_reg;
		logic [6:0] rxc_reg;
		logic [5:0] txw_reg;
		logic [5:0] txr_reg;
		logic [5:0] rxw_reg;
		logic [5:0] rxr_reg;
		wire        hit  = ch == 3'(i);
		wire  [1:0] tin  = hit ? tx_push_k : 2'h0;
		wire  [1:0] rout = hit ? rx_pop_k : 2'h0;
		wire        tout = tx_pop_ok & (tx_pop_ch == 3'(i));
		wire        rin  = rx_push_ok & (rx_push_ch == 3'(i));

		always_ff @(posedge clk)
		begin
			if (!rst_n)
			begin
				txc_reg <= 7'h00;
				rxc_reg <= 7'h00;
				txw_reg <= 6'h00;
				txr_reg <= 6'h00;
				rxw_reg <= 6'h00;
				rxr_reg <= 6'h00;
			end
			else
			begin
				txc_reg <= txc_reg + {5'h0, tin} - {6'h0, tout}; // R4
				txw_reg <= txw_reg + {4'h0, tin};
				txr_reg <= txr_reg + {5'h0, tout};
				rxc_reg <= rxc_reg + {6'h0, rin} - {5'h0, rout}; // R4
				rxw_reg <= rxw_reg + {5'h0, rin};
				rxr_reg <= rxr_reg + {4'h0, rout};
			end
		end

		assign tx_cnt[i]        = txc_reg;
		assign rx_cnt[i]        = rxc_reg;
		assign tx_wp[i]         = txw_reg;
		assign tx_rp[i]         = txr_reg;
		assign rx_wp[i]         = rxw_reg;
		assign rx_rp[i]         = rxr_reg;
		assign rx_full[i]       = rxc_reg == HBIC_DEPTH;
		assign tx_empty[i]      = txc_reg == 7'h00;
		assign ev[i]            = rin;
		assign ev[8 + i]        = tout & (txc_reg == 7'h01) & (tin == 2'h0);
		assign bus.dma_req[i]     = dmaen_reg[i] & (txc_reg != HBIC_DEPTH); // R5
		assign bus.dma_req[8 + i] = dmaen_reg[i] & (rxc_reg != 7'h00); // R5
	end

	// ==========================================================
	// Registers and interrupt status
	logic [15:0] ipc_reg;
	logic [15:0] istat_reg;
	logic [15:0] imask_reg;
	wire         reg_wr   = do_wr & ~fifo_sel;
	wire         wr_ipc   = reg_wr & (off == HBIC_OFF_IPC);
	wire         wr_imask = reg_wr & (off == HBIC_OFF_IMASK);
	wire         wr_dma   = reg_wr & (off == HBIC_OFF_DMAEN) & even_en;
	wire  [15:0] w1c      = (reg_wr & (off == HBIC_OFF_ISTAT)) ? (wword & be) : 16'h0000;
	wire  [15:0] pend     = istat_reg & imask_reg;
	wire         irq      = |pend;
	wire         daisy    = ipc_reg[HBIC_IPC_DAISY];
	wire  [2:0]  slave_id = ipc_reg[HBIC_IPC_ID +: 3];

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ipc_reg   <= HBIC_IPC_RESET;
			imask_reg <= HBIC_IMSK_RESET;
			dmaen_reg <= HBIC_DMA_RESET;
			istat_reg <= 16'h0000;
		end
		else
		begin
			if (wr_ipc)
				ipc_reg <= (ipc_reg & ~be) | (wword & be); // R7
			if (wr_imask)
				imask_reg <= (imask_reg & ~be) | (wword & be);
			if (wr_dma)
				dmaen_reg <= w_even;
			// A new event in the clearing cycle survives the clear.
			istat_reg <= (istat_reg & ~w1c) | ev;
		end
	end

	assign bus.int_n = ~irq;

	// ==========================================================
	// Read data and lane placement
	logic [3:0] pidx;

	always_comb
	begin
		pidx = 4'h0;
		for (int k = 15; k >= 0; k--)
			if (pend[k])
				pidx = 4'(k);
	end

	wire [7:0]  vector  = {ipc_reg[HBIC_IPC_VEC +: 4], pidx};
	wire [15:0] fifo_w  = rx_pop_ok ? {r_odd, r_even} : 16'h0000;
	wire [15:0] rd_word = fifo_sel ? fifo_w :
		(off == HBIC_OFF_LEVEL) ? {1'b0, h_tx_cnt, 1'b0, h_rx_cnt} :
		(off == HBIC_OFF_IPC)   ? ipc_reg :
		(off == HBIC_OFF_ISTAT) ? istat_reg :
		(off == HBIC_OFF_IMASK) ? imask_reg :
		(off == HBIC_OFF_DMAEN) ? {8'h00, dmaen_reg} : 16'h0000;
	wire [15:0] rd_bus  = ~bus16_reg ?
		{8'h00, bus.addr[0] ? rd_word[15:8] : rd_word[7:0]} :
		moto_reg ? {rd_word[7:0], rd_word[15:8]} : rd_word;
	wire        lo_drv  = ~bus16_reg | (moto_reg ? odd_en : even_en); // R16
	wire        hi_drv  = bus16_reg & (moto_reg ? even_en : odd_en); // R16

	// ==========================================================
	// Interrupt acknowledge and cascade
	logic ack_prev_reg;
	logic ack_seen_reg;
	logic vec_phase_reg;
	logic ack_sel_reg;
	logic [15:0] rdata_reg;
	wire  ack_on   = ~bus.interrupt_acknowledge_strobe_n;
	wire  ack_go   = ack_on & ~ack_prev_reg;
	// Strobe-pair style takes selection late, on the second pulse; the other style takes it as its one pulse starts.
	wire  vec_load = ack_go & (moto_reg | ack_seen_reg); // R9
	wire  sel_now  = daisy ? (bus.chain_enable_in & irq) : // R7 R10
		({bus.third_select_input, bus.chain_enable_in, bus.ie0_level} == slave_id); // R8
	wire  vec_rd   = moto_reg ? (~bus.host_data_strobe_n & bus.wr_rw) : 1'b1;
	wire  vec_drv  = vec_phase_reg & ack_sel_reg & ack_on & vec_rd; // R17
	wire  rd_drv   = acc_on & acc_prev_reg & is_rd;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			acc_prev_reg  <= 1'b0;
			ack_prev_reg  <= 1'b0;
			ack_seen_reg  <= 1'b0;
			vec_phase_reg <= 1'b0;
			ack_sel_reg   <= 1'b0;
			rdata_reg     <= 16'h0000;
		end
		else
		begin
			acc_prev_reg <= acc_on;
			ack_prev_reg <= ack_on;
			if (ack_go & ~moto_reg & ~ack_seen_reg)
				ack_seen_reg <= 1'b1; // R9
			else if (~ack_on & vec_phase_reg)
				ack_seen_reg <= 1'b0;
			if (vec_load)
			begin
				vec_phase_reg <= 1'b1;
				ack_sel_reg   <= sel_now; // R8
			end
			else if (~ack_on)
				vec_phase_reg <= 1'b0;
			if (do_rd)
				rdata_reg <= rd_bus;
			else if (vec_load)
				rdata_reg <= {8'h00, vector};
		end
	end

	assign bus.dev_dout              = rdata_reg;
	assign bus.dev_doe_n             = ~{rd_drv & hi_drv, (rd_drv & lo_drv) | vec_drv}; // R16 R17
	assign bus.chain_enable_out      = bus.chain_enable_in & ~irq; // R10
	assign bus.chain_enable_out_oe_n = ~daisy; // R10
endmodule : hbic_device

// ==== hw/hbic_host.sv ====
// Host end: bus cycle sequencer, lane glue and cascade strapping.
`timescale 1ns/1ps
module hbic_host
	import hbic_pkg::*;
(
	input  logic        clk,
	input  logic        rst_n,
	hbic_if.host        bus,
	input  logic        cfg_bus16,
	input  logic        cfg_moto,
	input  logic [3:0]  reg_addr,
	input  logic [15:0] reg_wdata,
	input  logic        reg_wr,
	input  logic        reg_rd,
	output logic [15:0] reg_rdata,
	output logic        irq,
	output logic [1:0]  port_size_acknowledge
);
	typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_RELEASE, HS_ACK1, HS_GAP, HS_ACK2}
		hbic_hstate_t;

	// ==========================================================
	// Command registers
	hbic_hstate_t state_reg;
	hbic_hstate_t state_next;
	logic [3:0]   cnt_reg;
	logic [3:0]   cnt_next;
	logic [8:0]   addr_reg;
	logic [15:0]  wdata_reg;
	logic [15:0]  rdata_reg;
	hbic_op_t     op_reg;
	logic         word_reg;
	logic [3:0]   sel_reg;
	logic [1:0]   istat_reg;
	logic [1:0]   imask_reg;
	logic         dev_irq_prev_reg;

	wire       idle     = state_reg == HS_IDLE;
	wire       go       = reg_wr & (reg_addr == HBIC_H_CMD) & idle;
	wire       done     = cnt_reg == 4'h0;
	wire       strobe   = state_reg == HS_STROBE;
	wire       in_acc   = (state_reg == HS_SETUP) | strobe;
	wire       ack2     = state_reg == HS_ACK2;
	wire       sample   = done & ((strobe & (op_reg == HBIC_OP_READ)) | ack2);
	wire       dev_irq  = ~bus.int_n;
	wire [1:0] ev       = {dev_irq & ~dev_irq_prev_reg, state_reg == HS_RELEASE};
	wire [1:0] w1c      = (reg_wr & (reg_addr == HBIC_H_ISTAT)) ? reg_wdata[1:0] : 2'h0;
	wire       daisy    = sel_reg[3];
	wire [1:0] size     = word_reg ? HBIC_SIZ_WORD : HBIC_SIZ_BYTE;
	wire       lane_n   = (size == HBIC_SIZ_BYTE) ? ~addr_reg[0] : 1'b0; // R3 R14
	wire [15:0] rd_mux  =
		(reg_addr == HBIC_H_ADDR)   ? {7'h00, addr_reg} :
		(reg_addr == HBIC_H_WDATA)  ? wdata_reg :
		(reg_addr == HBIC_H_CMD)    ? {13'h0000, word_reg, op_reg} :
		(reg_addr == HBIC_H_STATUS) ? {15'h0000, ~idle} :
		(reg_addr == HBIC_H_RDATA)  ? rdata_reg :
		(reg_addr == HBIC_H_SEL)    ? {12'h000, sel_reg} :
		(reg_addr == HBIC_H_ISTAT)  ? {14'h0000, istat_reg} :
		(reg_addr == HBIC_H_IMASK)  ? {14'h0000, imask_reg} : 16'h0000;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_reg  <= 9'h000;
			wdata_reg <= 16'h0000;
			op_reg    <= HBIC_OP_READ;
			word_reg  <= 1'b0;
			sel_reg   <= 4'h0;
			imask_reg <= 2'h0;
			istat_reg <= 2'h0;
			rdata_reg <= 16'h0000;
			reg_rdata <= 16'h0000;
			dev_irq_prev_reg <= 1'b0;
		end
		else
		begin
			if (reg_wr & (reg_addr == HBIC_H_ADDR) & idle)
				addr_reg <= reg_wdata[8:0];
			if (reg_wr & (reg_addr == HBIC_H_WDATA) & idle)
				wdata_reg <= reg_wdata;
			if (go)
			begin
				op_reg   <= hbic_op_t'(reg_wdata[1:0]);
				word_reg <= reg_wdata[2];
			end
			if (reg_wr & (reg_addr == HBIC_H_SEL))
				sel_reg <= reg_wdata[3:0];
			if (reg_wr & (reg_addr == HBIC_H_IMASK))
				imask_reg <= reg_wdata[1:0];
			// A new event in the clearing cycle survives the clear.
			istat_reg <= (istat_reg & ~w1c) | ev;
			if (sample)
				rdata_reg <= bus.data;
			if (reg_rd)
				reg_rdata <= rd_mux;
			dev_irq_prev_reg <= dev_irq;
		end
	end

	// ==========================================================
	// Bus cycle sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = done ? 4'h0 : cnt_reg - 4'h1;
		case (state_reg)
			HS_IDLE:
				if (go & (reg_wdata[1:0] == HBIC_OP_ACK))
				begin
					state_next = HS_ACK1; // R9
					cnt_next   = HBIC_STROBE_CYC - 4'h1;
				end
				else if (go)
					state_next = HS_SETUP;
			HS_SETUP:
			begin
				state_next = HS_STROBE;
				cnt_next   = HBIC_STROBE_CYC - 4'h1;
			end
			HS_STROBE:
				if (done)
					state_next = HS_RELEASE;
			HS_ACK1:
				if (done)
				begin
					state_next = HS_GAP; // R12 R13
					cnt_next   = HBIC_SETTLE_CYC - 4'h1;
				end
			HS_GAP:
				if (done)
				begin
					state_next = HS_ACK2; // R9
					cnt_next   = HBIC_STROBE_CYC - 4'h1;
				end
			HS_ACK2:
				if (done)
					state_next = HS_RELEASE;
			HS_RELEASE:
				state_next = HS_IDLE;
			default:
				state_next = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= HS_IDLE;
			cnt_reg   <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ==========================================================
	// Pin drive
	wire is_wr = op_reg == HBIC_OP_WRITE;
	wire ack_low = (state_reg == HS_ACK1) | ack2 | (cfg_moto & (state_reg == HS_GAP)); // R9 R13

	assign irq                          = |(istat_reg & imask_reg);
	assign bus.strap_bus16              = cfg_bus16;
	assign bus.strap_moto               = cfg_moto;
	assign bus.cs_n                     = ~in_acc;
	assign bus.addr                     = addr_reg;
	assign bus.upper_lane_enable_n      = lane_n; // R3
	assign bus.lower_lane_enable_n      = lane_n; // R14
	assign bus.host_data_strobe_n       = cfg_moto ? ~(strobe | ack2) : ~(strobe & ~is_wr);
	assign bus.wr_rw                    = cfg_moto ? ~(in_acc & is_wr) : ~(strobe & is_wr);
	assign bus.interrupt_acknowledge_strobe_n = ~ack_low;
	assign bus.host_dout                = wdata_reg;
	assign bus.host_doe_n               = ~(in_acc & is_wr);
	// The top device of a chain sees a high input and a fixed third line.
	assign bus.host_ie0                 = sel_reg[0];
	assign bus.host_ie0_oe_n            = daisy; // R10
	assign bus.chain_enable_in          = daisy ? 1'b1 : sel_reg[1]; // R10
	assign bus.third_select_input       = daisy ? 1'b0 : sel_reg[2]; // R11
	assign bus.dma_acknowledge_inputs_n = 8'hff; // R6
	assign port_size_acknowledge        = (strobe | ack2) ? HBIC_DSACK_16 : HBIC_DSACK_IDLE; // R15
endmodule : hbic_host

// ==== hw/hbic_if.sv ====
// Pins between the parallel host and the serial controller's host port.
`timescale 1ns/1ps
interface hbic_if;
	logic        cs_n;
	logic        host_data_strobe_n;
	logic        wr_rw;
	logic        interrupt_acknowledge_strobe_n;
	logic        upper_lane_enable_n;
	logic        lower_lane_enable_n;
	logic        strap_bus16;
	logic        strap_moto;
	logic [8:0]  addr;
	logic [15:0] host_dout;
	logic        host_doe_n;
	logic [15:0] dev_dout;
	logic [1:0]  dev_doe_n;
	logic [15:0] data;
	logic        chain_enable_out;
	logic        chain_enable_out_oe_n;
	logic        host_ie0;
	logic        host_ie0_oe_n;
	logic        ie0_level;
	logic        chain_enable_in;
	logic        third_select_input;
	logic        int_n;
	logic [15:0] dma_req;
	logic [7:0]  dma_acknowledge_inputs_n;

	// ==========================================================
	// Wire resolution; an undriven lane floats high.
	assign data[7:0]  = !dev_doe_n[0] ? dev_dout[7:0] :
		!host_doe_n ? host_dout[7:0] : 8'hff;
	assign data[15:8] = !dev_doe_n[1] ? dev_dout[15:8] :
		!host_doe_n ? host_dout[15:8] : 8'hff;
	assign ie0_level  = !chain_enable_out_oe_n ? chain_enable_out :
		!host_ie0_oe_n ? host_ie0 : 1'b1;

	modport dev (
		input  cs_n, host_data_strobe_n, wr_rw, interrupt_acknowledge_strobe_n,
		input  upper_lane_enable_n, lower_lane_enable_n, strap_bus16, strap_moto,
		input  addr, data, ie0_level, chain_enable_in, third_select_input,
		input  dma_acknowledge_inputs_n,
		output dev_dout, dev_doe_n, chain_enable_out, chain_enable_out_oe_n,
		output int_n, dma_req
	);
	modport host (
		output cs_n, host_data_strobe_n, wr_rw, interrupt_acknowledge_strobe_n,
		output upper_lane_enable_n, lower_lane_enable_n, strap_bus16, strap_moto,
		output addr, host_dout, host_doe_n, host_ie0, host_ie0_oe_n,
		output chain_enable_in, third_select_input, dma_acknowledge_inputs_n,
		input  data, ie0_level, int_n, dma_req
	);
endinterface : hbic_if

// ==== hw/hbic_pkg.sv ====
// Shared constants and types of the host bus and interrupt cascade block.
package hbic_pkg;
	// ==========================================================
	// Sizes
	localparam int unsigned HBIC_NCH   = 8;
	localparam logic [6:0]  HBIC_DEPTH = 7'h40;
	// ==========================================================
	// Device register offsets inside each 64-byte channel window
	localparam logic [5:0]  HBIC_OFF_FIFO  = 6'h00;
	localparam logic [5:0]  HBIC_OFF_LEVEL = 6'h02;
	localparam logic [5:0]  HBIC_OFF_IPC   = 6'h04;
	localparam logic [5:0]  HBIC_OFF_ISTAT = 6'h06;
	localparam logic [5:0]  HBIC_OFF_IMASK = 6'h08;
	localparam logic [5:0]  HBIC_OFF_DMAEN = 6'h0a;
	// ==========================================================
	// Fields of interrupt_port_config and reset values
	localparam int unsigned HBIC_IPC_DAISY  = 0;
	localparam int unsigned HBIC_IPC_ID     = 1;
	localparam int unsigned HBIC_IPC_VEC    = 4;
	localparam logic [15:0] HBIC_IPC_RESET  = 16'h0000;
	localparam logic [15:0] HBIC_IMSK_RESET = 16'h0000;
	localparam logic [7:0]  HBIC_DMA_RESET  = 8'h00;
	// ==========================================================
	// Host controller register addresses
	localparam logic [3:0]  HBIC_H_ADDR   = 4'h0;
	localparam logic [3:0]  HBIC_H_WDATA  = 4'h1;
	localparam logic [3:0]  HBIC_H_CMD    = 4'h2;
	localparam logic [3:0]  HBIC_H_STATUS = 4'h3;
	localparam logic [3:0]  HBIC_H_RDATA  = 4'h4;
	localparam logic [3:0]  HBIC_H_SEL    = 4'h5;
	localparam logic [3:0]  HBIC_H_ISTAT  = 4'h6;
	localparam logic [3:0]  HBIC_H_IMASK  = 4'h7;
	// ==========================================================
	// Timing and codes
	localparam logic [3:0]  HBIC_STROBE_CYC = 4'h3;
	localparam logic [3:0]  HBIC_SETTLE_CYC = 4'h2;
	localparam logic [1:0]  HBIC_DSACK_16   = 2'h1;
	localparam logic [1:0]  HBIC_DSACK_IDLE = 2'h3;
	localparam logic [1:0]  HBIC_SIZ_BYTE   = 2'h1;
	localparam logic [1:0]  HBIC_SIZ_WORD   = 2'h2;
	typedef enum logic [1:0] {HBIC_OP_READ, HBIC_OP_WRITE, HBIC_OP_ACK} hbic_op_t;
endpackage : hbic_pkg

// ==== verif/hbic_props.sv ====
// Concurrent checks on the wires between the host and device ends.
`timescale 1ns/1ps
module hbic_props (
	input logic        clk,
	input logic        rst_n,
	input logic        cs_n,
	input logic        host_data_strobe_n,
	input logic        wr_rw,
	input logic        interrupt_acknowledge_strobe_n,
	input logic        upper_lane_enable_n,
	input logic        strap_bus16,
	input logic        strap_moto,
	input logic [8:0]  addr,
	input logic [1:0]  dev_doe_n,
	input logic        chain_enable_out,
	input logic        chain_enable_out_oe_n,
	input logic        int_n,
	input logic [15:0] dma_req
);
	// ==========================================================
	// Checks; lane checks cover the sixteen-bit strobe-pair style only.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire rd_go = !cs_n && !host_data_strobe_n && wr_rw && interrupt_acknowledge_strobe_n
		&& strap_bus16 && !strap_moto;
	a_int_after_reset: assert property ($rose(rst_n) |-> int_n)
		else $error("interrupt active after reset");
	a_dma_after_reset: assert property ($rose(rst_n) |-> dma_req == 16'h0000)
		else $error("dma request after reset");
	a_idle_released: assert property (cs_n && interrupt_acknowledge_strobe_n
		|-> dev_doe_n == 2'h3) else $error("data driven while idle");
	a_write_released: assert property (!cs_n && !wr_rw && !strap_moto
		|-> dev_doe_n == 2'h3) else $error("data driven during write");
	a_word_lanes: assert property ($rose(rd_go) && !upper_lane_enable_n && !addr[0]
		|=> dev_doe_n == 2'h0) else $error("word read lanes wrong");
	a_even_lane: assert property ($rose(rd_go) && upper_lane_enable_n && !addr[0]
		|=> dev_doe_n == 2'h2) else $error("even byte lane wrong");
	a_odd_lane: assert property ($rose(rd_go) && !upper_lane_enable_n && addr[0]
		|=> dev_doe_n == 2'h1) else $error("odd byte lane wrong");
	a_chain_held: assert property (!chain_enable_out_oe_n && !int_n
		|-> !chain_enable_out) else $error("chain passed on while pending");
	c_word_read: cover property ($rose(rd_go) && !upper_lane_enable_n);
	c_chain_low: cover property (!chain_enable_out_oe_n && !int_n);
	c_int_fell: cover property ($fell(int_n));
endmodule : hbic_props

// ==== verif/host_bus_interrupt_cascade_bench.sv ====
// Bench joining the host and device ends through the host port.
`timescale 1ns/1ps
module host_bus_interrupt_cascade_bench
	import hbic_pkg::*;
;
	logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_push = 0, tx_pop = 0;
	logic        rd_d = 0, pop_d = 0, m = 0, irq;
	logic [2:0]  ch = 3'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  rx_push_data = 8'h00, tx_pop_data, rx_full, tx_empty;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, q[$];
	logic [23:0] b;
	int          errors = 0, samples_checked = 0, seed = 63;
	hbic_if bus ();
	hbic_device hbic_device_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .rx_push(rx_push),
		.rx_push_ch(ch), .rx_push_data(rx_push_data), .rx_full(rx_full), .tx_pop(tx_pop),
		.tx_pop_ch(ch), .tx_pop_data(tx_pop_data), .tx_empty(tx_empty));
	hbic_host hbic_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .cfg_bus16(1'b1),
		.cfg_moto(m), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .port_size_acknowledge());
	hbic_props hbic_props_inst (.clk(clk), .rst_n(rst_n), .cs_n(bus.cs_n),
		.host_data_strobe_n(bus.host_data_strobe_n), .wr_rw(bus.wr_rw),
		.interrupt_acknowledge_strobe_n(bus.interrupt_acknowledge_strobe_n),
		.upper_lane_enable_n(bus.upper_lane_enable_n), .strap_bus16(bus.strap_bus16),
		.strap_moto(bus.strap_moto), .addr(bus.addr), .dev_doe_n(bus.dev_doe_n),
		.chain_enable_out(bus.chain_enable_out), .int_n(bus.int_n), .dma_req(bus.dma_req),
		.chain_enable_out_oe_n(bus.chain_enable_out_oe_n));
	always #2 clk = ~clk;
	// ==========================================================
	// Checking and closing.
	task automatic conclude();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Results appear one cycle after the strobe that asks for them.
	always @(posedge clk)
	begin
		if (rd_d)
			chk("reg_rdata", reg_rdata, q.pop_front());
		if (pop_d)
			chk("tx_pop_data", {8'h00, tx_pop_data}, q.pop_front());
		rd_d <= reg_rd;
		pop_d <= tx_pop;
	end
	// ==========================================================
	// Drivers.
	// The other bus style puts the even byte on the upper lane, so raw words swap.
	function automatic logic [15:0] lanes(input logic [15:0] v);
		return m ? {v[7:0], v[15:8]} : v;
	endfunction : lanes
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		q.push_back(e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	// Done is awaited through the interrupt, so the host mask must hold bit 0.
	task automatic dev(input logic [8:0] a, input logic [15:0] v, input logic [2:0] c);
		int n = 0;
		wr(HBIC_H_ADDR, {7'h00, a});
		wr(HBIC_H_WDATA, v);
		wr(HBIC_H_CMD, {13'h0000, c});
		while (irq !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		chk("done_irq", {15'h0000, irq}, 16'h0001);
		wr(HBIC_H_ISTAT, 16'h0001);
	endtask : dev
	task automatic user(input logic p, input logic [7:0] v);
		if (!p)
			q.push_back({8'h00, v});
		@(posedge clk);
		rx_push <= p;
		tx_pop <= !p;
		rx_push_data <= v;
		@(posedge clk);
		rx_push <= 1'b0;
		tx_pop <= 1'b0;
	endtask : user
	initial
	begin
		repeat (1500) @(posedge clk);
		errors++;
		conclude();
	end
	initial
	begin
		for (int k = 0; k < 2; k++)
		begin
			// Straps are taken only after a reset, so each bus style gets its own.
			rst_n <= 1'b0;
			m <= 1'(k);
			repeat (6) @(posedge clk);
			rst_n <= 1'b1;
			ch <= 3'($random(seed));
			d = 16'($random(seed));
			b = 24'($random(seed));
			repeat (2) @(posedge clk);
			wr(HBIC_H_IMASK, 16'h0001);
			dev({ch, HBIC_OFF_DMAEN}, lanes(16'h00ff), 3'h5);
			dev({ch, HBIC_OFF_FIFO}, lanes(d), 3'h5);
			dev({ch, HBIC_OFF_LEVEL}, 16'h0000, 3'h4);
			rd(HBIC_H_RDATA, lanes(16'h0200));
			dev({ch, HBIC_OFF_LEVEL | 6'h01}, 16'h0000, 3'h0);
			rd(HBIC_H_RDATA, lanes(16'h02ff));
			user(1'b0, d[7:0]);
			user(1'b0, d[15:8]);
			user(1'b1, b[7:0]);
			user(1'b1, b[15:8]);
			user(1'b1, b[23:16]);
			chk("dma_req", bus.dma_req, {8'h01 << ch, 8'hff});
			chk("rx_full_tx_empty", {rx_full, tx_empty}, 16'h00ff);
			dev({ch, HBIC_OFF_FIFO}, 16'h0000, 3'h4);
			rd(HBIC_H_RDATA, lanes(b[15:0]));
			dev({ch, HBIC_OFF_FIFO}, 16'h0000, 3'h0);
			rd(HBIC_H_RDATA, lanes({8'hff, b[23:16]}));
			dev({ch, HBIC_OFF_IMASK}, 16'hffff, 3'h5);
			rd(HBIC_H_ISTAT, 16'h0002);
			dev({ch, HBIC_OFF_IPC}, lanes(16'h00a1), 3'h5);
			wr(HBIC_H_SEL, 16'h0008);
			dev(9'h000, 16'h0000, 3'h2);
			rd(HBIC_H_RDATA, {12'hffa, 1'b0, ch});
			wr(HBIC_H_SEL, 16'h0005);
			for (int i = 0; i < 2; i++)
			begin
				dev({ch, HBIC_OFF_IPC}, lanes(i ? 16'h00aa : 16'h00a4), 3'h5);
				dev(9'h000, 16'h0000, 3'h2);
				rd(HBIC_H_RDATA, i ? {12'hffa, 1'b0, ch} : 16'hffff);
			end
		end
		// The last read is compared two edges after its strobe.
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule : host_bus_interrupt_cascade_bench
